// ===== clk_sel_pkg.sv
// Constants for the system clock selector and monitor
package clk_sel_pkg;

    // Register indices (word offsets, byte address = index * 4)
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_STATUS   = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_PRESC    = 4'h4;
    localparam logic [3:0] REG_AUDIO    = 4'h5;

    // Control register fields
    localparam int CTRL_SEL_EXT  = 0;
    localparam int CTRL_MON_EN   = 1;
    localparam int CTRL_PLL_EN   = 2;
    localparam int CTRL_PLL_SRC  = 3;
    localparam int CTRL_AUD_EN   = 4;

    // Interrupt status bit positions
    localparam int IRQ_EXT_FAIL  = 0;
    localparam int IRQ_PLL_FAIL  = 1;
    localparam int IRQ_SWITCHED  = 2;
    localparam int IRQ_W         = 3;

    // Prescaler field layout: ahb[3:0], apb_hi[7:4], apb_lo[11:8]
    localparam int PRE_AHB_LSB   = 0;
    localparam int PRE_HI_LSB    = 4;
    localparam int PRE_LO_LSB    = 8;
    localparam int PRE_W         = 4;

    // Reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0002;
    localparam logic [31:0] PRESC_RST = 32'h0000_0000;
    localparam logic [31:0] AUDIO_RST = 32'h0000_0000;

    // Oscillator and limit figures
    localparam int INT_OSC_KHZ  = 16000;
    localparam int EXT_MIN_KHZ  = 4000;
    localparam int EXT_MAX_KHZ  = 26000;
    localparam int AHB_MAX_KHZ  = 120000;
    localparam int APB_HI_MAX_KHZ = 60000;
    localparam int APB_LO_MAX_KHZ = 30000;
    localparam int AUD_MIN_HZ   = 8000;
    localparam int AUD_MAX_HZ   = 192000;

    // Failure watchdog: no external edge within this time means dead
    localparam int SYS_CLK_MHZ  = 250;
    localparam int FAIL_TIME_NS = 1000;
    localparam int FAIL_CYCLES  = (FAIL_TIME_NS * SYS_CLK_MHZ) / 1000;

    // Switch sequencer states
    typedef enum logic [1:0] {
        SW_IDLE  = 2'b00,
        SW_DROP  = 2'b01,
        SW_TAKE  = 2'b10
    } sw_state_t;

endpackage : clk_sel_pkg

// ===== system_clock_selector_monitor.sv
// System clock selector with external clock failure monitor
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps

module system_clock_selector_monitor
    import clk_sel_pkg::*;
#(
    parameter int FAIL_CNT = FAIL_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // Oscillator activity, asynchronous levels
    input  wire logic        int_osc_i,
    input  wire logic        ext_osc_i,
    input  wire logic        pll_lock_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // Clock tree control
    output logic             int_gate_o,
    output logic             ext_gate_o,
    output logic             pll_en_o,
    output logic             pll_src_ext_o,
    output logic             audio_pll_en_o,
    output logic      [31:0] audio_cfg_o,
    output logic      [3:0]  ahb_div_o,
    output logic      [3:0]  apb_hi_div_o,
    output logic      [3:0]  apb_lo_div_o,
    // Interrupt
    output logic             irq_o
);

    localparam int CW = $clog2(FAIL_CNT + 1);

    typedef struct packed {
        logic [1:0]  int_sync;
        logic [1:0]  ext_sync;
        logic [1:0]  lock_sync;
        logic        ext_prev;
        logic [CW-1:0] ext_wd;
        logic        ext_dead;
        logic        lock_prev;
        logic [31:0] ctrl;
        logic [31:0] presc;
        logic [31:0] audio;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic        on_ext;
        logic        want_ext;
        logic        int_gate;
        logic        ext_gate;
        sw_state_t   sw;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic             ext_edge;
    logic             ext_fail;
    logic             pll_fail;
    logic [IRQ_W-1:0] ev;

    always_comb begin
        s_d = s_q;
        ev  = '0;

        // Two-stage synchronisers; only the second stage is read
        s_d.int_sync  = {s_q.int_sync[0], int_osc_i};
        s_d.ext_sync  = {s_q.ext_sync[0], ext_osc_i};
        s_d.lock_sync = {s_q.lock_sync[0], pll_lock_i};
        s_d.ext_prev  = s_q.ext_sync[1];
        s_d.lock_prev = s_q.lock_sync[1];

        // Watchdog restarts on every external edge
        ext_edge = s_q.ext_sync[1] != s_q.ext_prev;
        ext_fail = 1'b0;
        if (!s_q.ctrl[CTRL_MON_EN] || ext_edge) begin
            s_d.ext_wd   = '0;
            s_d.ext_dead = 1'b0;
        end else if (s_q.ext_wd == CW'(FAIL_CNT)) begin
            s_d.ext_dead = 1'b1;
            ext_fail     = !s_q.ext_dead;
        end else begin
            s_d.ext_wd = s_q.ext_wd + CW'(1);
        end

        // Lock loss or a dead source on a PLL fed from the external clock
        pll_fail = ((s_q.lock_prev && !s_q.lock_sync[1]) || ext_fail) &&
                   s_q.ctrl[CTRL_PLL_EN] && s_q.ctrl[CTRL_PLL_SRC];

        // Desired source; an external clock the monitor has marked dead is never chosen
        s_d.want_ext = s_q.ctrl[CTRL_SEL_EXT] && !s_q.ext_dead;

        // Glitch-free switch: drop old gate on its low phase, then take new
        case (s_q.sw)
            SW_IDLE: begin
                if (s_q.want_ext != s_q.on_ext) begin
                    s_d.sw = SW_DROP;
                end
            end
            SW_DROP: begin
                // A dead external clock cannot be waited on
                if (s_q.on_ext && (!s_q.ext_sync[1] || s_q.ext_dead)) begin
                    s_d.ext_gate = 1'b0;
                    s_d.sw       = SW_TAKE;
                end else if (!s_q.on_ext && !s_q.int_sync[1]) begin
                    s_d.int_gate = 1'b0;
                    s_d.sw       = SW_TAKE;
                end
            end
            SW_TAKE: begin
                if (!s_q.on_ext && (s_q.ext_dead || !s_q.want_ext)) begin
                    // Target lost mid-switch; both gates must not stay shut
                    if (!s_q.int_sync[1]) begin
                        s_d.int_gate = 1'b1;
                        s_d.sw       = SW_IDLE;
                    end
                end else if (!s_q.on_ext && !s_q.ext_sync[1]) begin
                    s_d.ext_gate = 1'b1;
                    s_d.on_ext   = 1'b1;
                    s_d.sw       = SW_IDLE;
                    ev[IRQ_SWITCHED] = 1'b1;
                end else if (s_q.on_ext && !s_q.int_sync[1]) begin
                    s_d.int_gate = 1'b1;
                    s_d.on_ext   = 1'b0;
                    s_d.sw       = SW_IDLE;
                    ev[IRQ_SWITCHED] = 1'b1;
                end
            end
            default: begin
                s_d.sw = SW_IDLE;
            end
        endcase

        ev[IRQ_EXT_FAIL] = ext_fail && s_q.on_ext;
        ev[IRQ_PLL_FAIL] = pll_fail;

        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CTRL:     s_d.ctrl     = reg_wdata_i;
                REG_PRESC:    s_d.presc    = reg_wdata_i;
                REG_AUDIO:    s_d.audio    = reg_wdata_i;
                REG_IRQ_MASK: s_d.irq_mask = reg_wdata_i[IRQ_W-1:0];
                REG_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~reg_wdata_i[IRQ_W-1:0];
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        s_d.irq_stat = s_d.irq_stat | ev;

        // Read data in the cycle after the strobe only
        s_d.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL:     s_d.rdata = s_q.ctrl;
                REG_STATUS:   s_d.rdata = {28'h000_0000, s_q.sw == SW_IDLE,
                                           s_q.lock_sync[1], s_q.ext_dead, s_q.on_ext};
                REG_IRQ_STAT: s_d.rdata = {29'h0000_0000, s_q.irq_stat};
                REG_IRQ_MASK: s_d.rdata = {29'h0000_0000, s_q.irq_mask};
                REG_PRESC:    s_d.rdata = s_q.presc;
                REG_AUDIO:    s_d.rdata = s_q.audio;
                default:      s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q          <= '0;
            s_q.ctrl     <= CTRL_RST;
            s_q.presc    <= PRESC_RST;
            s_q.audio    <= AUDIO_RST;
            s_q.int_gate <= 1'b1;
            s_q.on_ext   <= 1'b0;
            s_q.sw       <= SW_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Both gates drive one tree root for core and peripherals
    assign int_gate_o     = s_q.int_gate;
    assign ext_gate_o     = s_q.ext_gate;
    assign pll_en_o       = s_q.ctrl[CTRL_PLL_EN];
    assign pll_src_ext_o  = s_q.ctrl[CTRL_PLL_SRC];
    assign audio_pll_en_o = s_q.ctrl[CTRL_AUD_EN];
    assign audio_cfg_o    = s_q.audio;
    // Limits are software's; divisors pass unchecked
    assign ahb_div_o      = s_q.presc[PRE_AHB_LSB +: PRE_W];
    assign apb_hi_div_o   = s_q.presc[PRE_HI_LSB +: PRE_W];
    assign apb_lo_div_o   = s_q.presc[PRE_LO_LSB +: PRE_W];
    assign reg_rdata_o    = s_q.rdata;
    assign irq_o          = |(s_q.irq_stat & s_q.irq_mask);

endmodule : system_clock_selector_monitor

// ===== clk_sel_props.sv
// Port checker for the clock selector and monitor
`timescale 1ns/1ps

module clk_sel_props
    import clk_sel_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o, audio_cfg_o,
    // Clock tree control and interrupt
    input wire logic        int_gate_o, ext_gate_o, pll_en_o, pll_src_ext_o,
    input wire logic        audio_pll_en_o, irq_o,
    input wire logic [3:0]  ahb_div_o, apb_hi_div_o, apb_lo_div_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    a_gates_exclusive: assert property (!(int_gate_o && ext_gate_o))
        else $error("both clock gates open");
    a_reset_internal: assert property ($rose(arst_n_i) |-> int_gate_o && !ext_gate_o)
        else $error("reset did not select internal oscillator");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > REG_AUDIO |=> reg_rdata_o == 0)
        else $error("unmapped read not zero");
    a_presc_update: assert property (reg_wr_i && reg_addr_i == REG_PRESC |=>
        {apb_lo_div_o, apb_hi_div_o, ahb_div_o} == $past(reg_wdata_i[11:0]))
        else $error("prescaler outputs wrong");
    a_audio_update: assert property (reg_wr_i && reg_addr_i == REG_AUDIO |=>
        audio_cfg_o == $past(reg_wdata_i))
        else $error("audio config wrong");
    a_ctrl_update: assert property (reg_wr_i && reg_addr_i == REG_CTRL |=>
        {audio_pll_en_o, pll_src_ext_o, pll_en_o} == $past(reg_wdata_i[4:2]))
        else $error("control outputs wrong");
    a_mask_silences: assert property (reg_wr_i && reg_addr_i == REG_IRQ_MASK &&
        reg_wdata_i[2:0] == 3'h0 |=> !irq_o)
        else $error("masked interrupt still high");

    c_to_ext: cover property ($rose(ext_gate_o));
    c_fallback: cover property ($fell(ext_gate_o) ##[1:100] int_gate_o);
    c_irq: cover property ($rose(irq_o));
endmodule : clk_sel_props

bind system_clock_selector_monitor clk_sel_props u_props (.*);

// ===== ext_osc_model.sv
// Oscillator models feeding the selector
`timescale 1ns/1ps

module ext_osc_model (
    // Control
    input  wire logic run_i,
    // Oscillator outputs
    output logic      int_osc_o,
    output logic      ext_osc_o
);
    initial int_osc_o = 1'b0;
    initial ext_osc_o = 1'b0;
    // Internal RC at 16 MHz
    always #31.25 int_osc_o = ~int_osc_o;
    // External at 25 MHz; a dead crystal freezes at its last level
    always #20 if (run_i) ext_osc_o = ~ext_osc_o;
endmodule : ext_osc_model

// ===== system_clock_selector_monitor_tb_top.sv
// Register level testbench for the clock selector and monitor
`timescale 1ns/1ps

module system_clock_selector_monitor_tb_top
    import clk_sel_pkg::*;
;
    logic clk_sys_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, pll_lock_i = 1, run = 1;
    logic [3:0]  reg_addr_i = 0, ahb, hi, lo;
    logic [31:0] reg_wdata_i = 0, rdata, aud;
    logic        io, eo, int_gate, ext_gate, pll_en, pll_src, aud_en, irq;
    int          num_errors = 0, n_checks = 0;

    always #2 clk_sys_i = ~clk_sys_i;
    ext_osc_model u_osc (.run_i(run), .int_osc_o(io), .ext_osc_o(eo));
    system_clock_selector_monitor #(.FAIL_CNT(16)) u_dut (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .int_osc_i(io), .ext_osc_i(eo), .pll_lock_i(pll_lock_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .int_gate_o(int_gate),
        .ext_gate_o(ext_gate), .pll_en_o(pll_en), .pll_src_ext_o(pll_src),
        .audio_pll_en_o(aud_en), .audio_cfg_o(aud), .ahb_div_o(ahb),
        .apb_hi_div_o(hi), .apb_lo_div_o(lo), .irq_o(irq));

    task automatic tally_and_finish();
        if (num_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(rdata & m, e);
    endtask : rd
    // 0: interrupt high, 1: on external, 2: on internal
    task automatic wait_on(input int w);
        for (int i = 0; i < 500; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (w == 0 ? irq === 1'b1 : {ext_gate, int_gate} === (w == 1 ? 2'b10 : 2'b01))
                return;
        end
        num_errors++;
        $display("[FAIL] %0t wait ran out", $time);
        tally_and_finish();
    endtask : wait_on

    initial begin
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 chk({ext_gate, int_gate}, 2'b01);
        rd(REG_CTRL, 32'hFFFF_FFFF, CTRL_RST);
        rd(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(REG_PRESC, 32'h0000_0210);
        chk({lo, hi, ahb}, 12'h210);
        rd(REG_PRESC, 32'hFFFF_FFFF, 32'h0000_0210);
        wr(REG_AUDIO, 32'h1234_5678);
        chk(aud, 32'h1234_5678);
        wr(REG_CTRL, 32'h0000_001E);
        chk({aud_en, pll_src, pll_en}, 3'b111);
        wr(REG_IRQ_MASK, 32'h0000_0007);
        rd(REG_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0007);
        @(posedge clk_sys_i) pll_lock_i <= 1'b0;
        wait_on(0);
        rd(REG_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
        @(posedge clk_sys_i) pll_lock_i <= 1'b1;
        wr(REG_IRQ_STAT, 32'h0000_0007);
        chk(irq, 1'b0);
        wr(REG_CTRL, 32'h0000_001F);
        wait_on(1);
        rd(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        rd(REG_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
        // Mid-run reset while running from the external clock
        @(posedge clk_sys_i) arst_n_i <= 1'b0;
        @(posedge clk_sys_i) arst_n_i <= 1'b1;
        @(posedge clk_sys_i) #1 chk({ext_gate, int_gate}, 2'b01);
        rd(REG_CTRL, 32'hFFFF_FFFF, CTRL_RST);
        rd(REG_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(REG_IRQ_MASK, 32'h0000_0007);
        wr(REG_CTRL, 32'h0000_001F);
        wait_on(1);
        wr(REG_IRQ_STAT, 32'h0000_0007);
        run <= 1'b0;
        wait_on(2);
        rd(REG_STATUS, 32'h0000_000F, 32'h0000_000E);
        rd(REG_IRQ_STAT, 32'h0000_0003, 32'h0000_0003);
        chk(irq, 1'b1);
        wr(REG_IRQ_MASK, 32'h0000_0000);
        chk(irq, 1'b0);
        tally_and_finish();
    end
endmodule : system_clock_selector_monitor_tb_top
